// >>> hdl/ind_read_pkg.sv
/*
 * Constants for the indirect register read path behind the I2C slave.
 * Assumes one device clock; bit 0 of a 32-bit word is its MSB (big-endian labels).
 */
// How it works
// (RULE1) Read address keeps its two lowest bits at zero always.
// (RULE2) Read address is read/write at peripheral 0x10-0x13, read-only internally.
// (RULE3) Only the low 24 address bits reach the internal bus; top byte stored.
// (RULE4) With auto-increment set, reading byte 0x14 adds 4 to the address; here only when that read launches (4-byte size, idle).
// (RULE5) Read data sits at peripheral 0x14-0x17, read-only from both sides.
// (RULE6) In 4-byte size, reading 0x14 launches a read; 0x14 returns bits 24:31.
// (RULE7) The internal read uses the address currently held in the register.
// (RULE8) Reads of 0x15-0x17 return stored bytes with no internal access.
// (RULE9) After reading 0x17 the peripheral pointer wraps back to 0x14.
// (RULE10) Writing 0x17 advances the pointer to 0x18, no wrap.
// (RULE11) Address and data registers reset to zero.
// (RULE12) Success flag sets on a completed internal read; cleared by reading 0x20.
// (RULE13) Otherwise the pointer increments by one after every byte.
// (RULE14) Master loads the address first and waits for the read before use.
package ind_read_pkg;
    localparam logic [19:0] OFS_READ_ADDRESS = 20'h1D210;
    localparam logic [19:0] OFS_READ_DATA    = 20'h1D214;
    localparam logic [7:0]  PA_ADDR_LO       = 8'h10;
    localparam logic [7:0]  PA_ADDR_HI       = 8'h13;
    localparam logic [7:0]  PA_DATA_LO       = 8'h14;
    localparam logic [7:0]  PA_DATA_HI       = 8'h17;
    localparam logic [7:0]  PA_STATUS        = 8'h20;
    localparam logic [31:0] RST_WORD         = 32'h0000_0000;
    localparam logic [31:0] ADDR_STEP        = 32'h0000_0004;
    localparam logic [31:0] ALIGN_MASK       = 32'hFFFF_FFFC;
    localparam logic [23:0] BUS_ADDR_MASK    = 24'hFF_FFFF;
    localparam logic [7:0]  STAT_OK_BIT      = 8'h80;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } rd_state_t;
endpackage : ind_read_pkg

// >>> hdl/ind_read_path.sv
/*
 * Indirect internal-register read path of the I2C slave.
 * Assumes the I2C front end presents one-cycle byte strobes with a current
 * pointer, and the internal register bus answers reads with a done pulse.
 * Only one internal read is outstanding; a read of 0x14 while busy returns its byte but starts no new read.
 * The register bus view answers one cycle after reg_addr; unmapped offsets read 0.
 * Offset 0 of a byte window is the least significant byte of the word.
 */
`timescale 1ns/100ps
module ind_read_path
    import ind_read_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // I2C slave byte side
    input  wire logic        byte_wr,
    input  wire logic        byte_rd,
    input  wire logic [7:0]  byte_wdata,
    input  wire logic        ptr_load,
    input  wire logic [7:0]  ptr_load_val,
    output logic      [7:0]  periph_ptr,
    output logic      [7:0]  byte_rdata,
    // access control bits
    input  wire logic        read_auto_increment,
    input  wire logic        read_access_size,
    // internal register bus master
    output logic             ibus_rd,
    output logic      [23:0] ibus_addr,
    input  wire logic        ibus_done,
    input  wire logic        ibus_ok,
    input  wire logic [31:0] ibus_rdata,
    // internal register bus view (read-only)
    input  wire logic [19:0] reg_addr,
    output logic      [31:0] reg_rdata,
    // status
    output logic             access_success_flag,
    output logic             read_busy
);
    import ind_read_pkg::*;

    // registered state and next values
    logic [7:0]  ptr_r, ptr_nxt;
    logic [7:0]  rbyte_r, rbyte_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [31:0] data_r, data_nxt;
    logic        ok_r, ok_nxt;
    logic        rd_r, rd_nxt;
    logic [23:0] baddr_r, baddr_nxt;
    logic [31:0] regq_r, regq_nxt;
    rd_state_t   st_r, st_nxt;

    // byte lane select: offset 0 is bits 24:31 in big-endian labels
    function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] k);
        case (k)
            2'd0:    lane = w[7:0];
            2'd1:    lane = w[15:8];
            2'd2:    lane = w[23:16];
            default: lane = w[31:24];
        endcase
    endfunction : lane

    // pointer inside the address window 0x10-0x13
    function automatic logic in_addr_win(input logic [7:0] p);
        in_addr_win = (p >= PA_ADDR_LO) && (p <= PA_ADDR_HI);
    endfunction : in_addr_win

    // pointer inside the data window 0x14-0x17
    function automatic logic in_data_win(input logic [7:0] p);
        in_data_win = (p >= PA_DATA_LO) && (p <= PA_DATA_HI);
    endfunction : in_data_win

    // pointer after a byte read: the data window wraps at its top byte
    function automatic logic [7:0] ptr_after_read(input logic [7:0] p);
        if (p == PA_DATA_HI)
        begin
            ptr_after_read = PA_DATA_LO;                           // [RULE9]
        end
        else
        begin
            ptr_after_read = p + 8'h01;                            // [RULE13]
        end
    endfunction : ptr_after_read

    // next-state logic for pointer, registers and the internal read
    always_comb
    begin
        ptr_nxt   = ptr_r;
        addr_nxt  = addr_r;
        data_nxt  = data_r;
        ok_nxt    = ok_r;
        rd_nxt    = 1'b0;
        baddr_nxt = baddr_r;
        st_nxt    = st_r;
        rbyte_nxt = rbyte_r;
        // pointer load wins over both byte strobes
        if (ptr_load)
        begin
            ptr_nxt = ptr_load_val;
        end
        else if (byte_wr)
        begin
            // only the address window takes writes; data bytes stay read-only
            if (in_addr_win(ptr_r))
            begin
                // [RULE2] byte write; [RULE3] top byte stored anyway
                addr_nxt[8*(ptr_r[1:0])+:8] = byte_wdata;
                addr_nxt = addr_nxt & ALIGN_MASK;                  // [RULE1]
            end
            ptr_nxt = ptr_r + 8'h01;                               // [RULE10] [RULE13]
        end
        else if (byte_rd)
        begin
            // byte source chosen by window
            if (in_addr_win(ptr_r))
            begin
                rbyte_nxt = lane(addr_r, ptr_r[1:0]);              // [RULE2]
            end
            else if (in_data_win(ptr_r))
            begin
                rbyte_nxt = lane(data_r, ptr_r[1:0]);              // [RULE5] [RULE8]
            end
            // status byte: flag in the top bit, cleared by this read
            else if (ptr_r == PA_STATUS)
            begin
                rbyte_nxt = ok_r ? STAT_OK_BIT : 8'h00;
                ok_nxt    = 1'b0;                                  // [RULE12]
            end
            else
            begin
                rbyte_nxt = 8'h00;
            end
            // launch on the low data byte only when idle and sized for words
            if (ptr_r == PA_DATA_LO && read_access_size && st_r == ST_IDLE)
            begin
                rd_nxt    = 1'b1;                                  // [RULE6]
                baddr_nxt = addr_r[23:0] & BUS_ADDR_MASK;          // [RULE3] [RULE7]
                st_nxt    = ST_WAIT;
                ok_nxt    = 1'b0;
                // the address steps only together with a launch
                if (read_auto_increment)
                begin
                    addr_nxt = (addr_r + ADDR_STEP) & ALIGN_MASK;  // [RULE4]
                end
            end
            ptr_nxt = ptr_after_read(ptr_r);                       // [RULE9] [RULE13]
        end
        // a read completion with ibus_ok loads data and flags success; set beats clear
        if (st_r == ST_WAIT && ibus_done)
        begin
            st_nxt = ST_IDLE;
            if (ibus_ok)
            begin
                data_nxt = ibus_rdata;                             // [RULE6]
                ok_nxt   = 1'b1;                                   // [RULE12]
            end
        end
    end

    // state registers; all clear to zero so power-up reads as idle
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ptr_r   <= 8'h00;
            rbyte_r <= 8'h00;
            addr_r  <= RST_WORD;                                   // [RULE11]
            data_r  <= RST_WORD;                                   // [RULE11]
            ok_r    <= 1'b0;
            rd_r    <= 1'b0;
            baddr_r <= 24'h00_0000;
            st_r    <= ST_IDLE;
        end
        else
        begin
            ptr_r   <= ptr_nxt;
            rbyte_r <= rbyte_nxt;
            addr_r  <= addr_nxt;
            data_r  <= data_nxt;
            ok_r    <= ok_nxt;
            rd_r    <= rd_nxt;
            baddr_r <= baddr_nxt;
            st_r    <= st_nxt;
        end
    end

    // internal read-only view: decode of the register bus offset
    always_comb
    begin
        regq_nxt = RST_WORD;
        if (reg_addr == OFS_READ_ADDRESS)
        begin
            regq_nxt = addr_r;                                     // [RULE2]
        end
        else if (reg_addr == OFS_READ_DATA)
        begin
            regq_nxt = data_r;                                     // [RULE5]
        end
        else
        begin
            regq_nxt = RST_WORD;                                   // unmapped reads zero
        end
    end

    // register view flip-flop
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            regq_r <= RST_WORD;
        end
        else
        begin
            regq_r <= regq_nxt;
        end
    end

    // outputs straight from flip-flops
    assign periph_ptr          = ptr_r;
    assign byte_rdata          = rbyte_r;
    assign ibus_rd             = rd_r;
    assign ibus_addr           = baddr_r;
    assign reg_rdata           = regq_r;
    assign access_success_flag = ok_r;
    // busy mirrors the wait state of the single-read machine
    assign read_busy           = st_r;
endmodule : ind_read_path

// >>> bench/ind_read_path_asserts.sv
/* checker for the indirect read path; sees only the top ports, bound from testbench */
`timescale 1ns/100ps
module ind_read_chk (
    input wire logic        clk_sys, reset, byte_wr, byte_rd, ptr_load, read_access_size,
    input wire logic        read_busy, ibus_rd, ibus_done, ibus_ok, access_success_flag,
    input wire logic [7:0]  periph_ptr,
    input wire logic [23:0] ibus_addr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // a byte read that no load or write overrides
    wire logic rd_ok = byte_rd && !ptr_load && !byte_wr;
    AST_ALIGN: assert property (ibus_rd |-> ibus_addr[1:0] == 2'h0)
        else $error("unaligned bus address");
    AST_LAUNCH: assert property (rd_ok && periph_ptr == 8'h14 && read_access_size && !read_busy
        |=> ibus_rd ##1 !ibus_rd) else $error("no launch");
    AST_ONLY14: assert property (ibus_rd |-> $past(rd_ok) && $past(periph_ptr) == 8'h14)
        else $error("stray launch");
    AST_HOLD: assert property (!ibus_rd |-> $stable(ibus_addr))
        else $error("bus address moved");
    AST_WRAP: assert property (rd_ok && periph_ptr == 8'h17 |=> periph_ptr == 8'h14)
        else $error("no wrap");
    AST_STEP: assert property (!ptr_load && (byte_wr || rd_ok && periph_ptr != 8'h17)
        |=> periph_ptr == $past(periph_ptr) + 8'h01) else $error("bad step");
    AST_FLAG: assert property (ibus_done && ibus_ok && read_busy |=> access_success_flag)
        else $error("flag not set");
    AST_CLR: assert property (rd_ok && periph_ptr == 8'h20 && !(ibus_done && read_busy)
        |=> !access_success_flag) else $error("flag not cleared");
    COV_LAUNCH: cover property (ibus_rd);
    COV_WRAP: cover property (rd_ok && periph_ptr == 8'h17);
    COV_DONE: cover property (ibus_done && read_busy);
    COV_FAIL: cover property (ibus_done && !ibus_ok && read_busy);
endmodule : ind_read_chk

// >>> bench/ibus_responder.sv
/* internal register bus responder; answers each request lat+1 cycles after it samples ibus_rd */
`timescale 1ns/100ps
module ibus_responder (
    input wire logic        clk_sys, reset, ibus_rd,
    input wire logic [23:0] ibus_addr,
    input wire logic [3:0]  lat,
    output logic            ibus_done, ibus_ok,
    output logic [31:0]     ibus_rdata
);
    logic [3:0] cnt_r;
    logic       busy_r;
    // count down, then answer with a word made from the held address
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            {busy_r, cnt_r, ibus_done, ibus_ok, ibus_rdata} <= '0;
        else
        begin
            ibus_done  <= 1'b0;
            ibus_ok    <= ~ibus_ok;     // meaningless outside done
            ibus_rdata <= ~ibus_rdata;
            if (ibus_rd)
                {busy_r, cnt_r} <= {1'b1, lat};
            else if (busy_r && cnt_r == 4'h0)
            begin
                {busy_r, ibus_done, ibus_ok} <= {2'b01, lat != 4'h7}; // lat 7 answers an error
                ibus_rdata <= {ibus_addr[7:0] ^ 8'hC3, ibus_addr};
            end
            else
                cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule : ibus_responder

// >>> bench/testbench.sv
/* self-checking bench for ind_read_path; plays the I2C master byte side */
`timescale 1ns/100ps
module testbench;
    import ind_read_pkg::*;
    logic clk_sys, reset, byte_wr, byte_rd, ptr_load, read_auto_increment, read_access_size;
    logic ibus_rd, ibus_done, ibus_ok, read_busy, access_success_flag;
    logic [7:0]  byte_wdata, ptr_load_val, periph_ptr, byte_rdata;
    logic [23:0] ibus_addr;
    logic [31:0] ibus_rdata, reg_rdata, a, e, p;
    logic [19:0] reg_addr;
    logic [3:0]  lat;
    int          bad_count, check_count, i, k, n;
    ind_read_path dut_u (.clk_sys, .reset, .byte_wr, .byte_rd, .byte_wdata, .ptr_load,
        .ptr_load_val, .periph_ptr, .byte_rdata, .read_auto_increment, .read_access_size,
        .ibus_rd, .ibus_addr, .ibus_done, .ibus_ok, .ibus_rdata, .reg_addr, .reg_rdata,
        .access_success_flag, .read_busy);
    ibus_responder resp_u (.clk_sys, .reset, .ibus_rd, .ibus_addr, .lat, .ibus_done, .ibus_ok,
        .ibus_rdata);
    function automatic logic [31:0] exp_word(input logic [31:0] ad);
        return {(ad[7:0] & 8'hFC) ^ 8'hC3, ad[23:2], 2'h0};
    endfunction : exp_word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one strobe cycle: write, read, or pointer load when neither
    task automatic op(input logic w, input logic r, input logic [7:0] d, input logic [7:0] p);
        @(posedge clk_sys);
        {ptr_load, byte_wr, byte_rd, byte_wdata, ptr_load_val} <= {!w && !r, w, r, d, p};
        @(posedge clk_sys);
        {ptr_load, byte_wr, byte_rd} <= 3'h0;
        #1;
    endtask : op
    task automatic rreg(input logic [19:0] ad);
        @(posedge clk_sys);
        reg_addr <= ad;
        @(posedge clk_sys);
        #1;
    endtask : rreg
    // bounded wait for the internal read to finish
    task automatic wait_idle;
        for (n = 0; n < 40 && read_busy !== 1'b0; n++) @(posedge clk_sys) #1;
        if (n == 40)
        begin
            bad_count++;
            summarize;
        end
    endtask : wait_idle
    task automatic summarize;
        $display("checks=%0d bad=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial
    begin
        {reset, byte_wr, byte_rd, ptr_load, read_auto_increment, read_access_size} = 6'h20;
        {byte_wdata, ptr_load_val, reg_addr, lat, bad_count, check_count} = '0;
        p = RST_WORD;
        void'($urandom(12));
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        rreg(OFS_READ_ADDRESS); chk(reg_rdata, RST_WORD);
        rreg(OFS_READ_DATA); chk(reg_rdata, RST_WORD);
        for (i = 0; i < 6; i++)
        begin
            a = (i == 0) ? 32'hFFFF_FFFF : $urandom;
            e = exp_word(a);
            {read_auto_increment, read_access_size, lat} <= {i[0], 1'b1, 4'($urandom_range(0, 6))};
            op(0, 0, 8'h00, PA_ADDR_LO);
            for (k = 0; k < 4; k++) op(1, 0, a[8*k +: 8], 8'h00);
            chk(periph_ptr, PA_DATA_LO);
            rreg(OFS_READ_ADDRESS); chk(reg_rdata, a & ALIGN_MASK);
            op(0, 1, 8'h00, 8'h00);
            chk(byte_rdata, p[7:0]);
            chk(ibus_addr, a[23:0] & 24'hFF_FFFC);
            wait_idle;
            rreg(OFS_READ_DATA); chk(reg_rdata, e);
            for (k = 1; k < 4; k++) begin op(0, 1, 8'h00, 8'h00); chk(byte_rdata, e[8*k +: 8]); end
            chk(periph_ptr, PA_DATA_LO);
            rreg(OFS_READ_ADDRESS); chk(reg_rdata, (a & ALIGN_MASK) + (i[0] ? ADDR_STEP : 0));
            op(0, 0, 8'h00, PA_STATUS); op(0, 1, 8'h00, 8'h00); chk(byte_rdata, STAT_OK_BIT);
            chk(access_success_flag, 0);
            p = e;
            $display("test block %0d done", i);
        end
        read_access_size <= 1'b0;
        op(0, 0, 8'h00, PA_DATA_LO); op(0, 1, 8'h00, 8'h00); chk(read_busy, 0);
        chk(byte_rdata, e[7:0]);
        op(0, 0, 8'h00, PA_DATA_HI); op(1, 0, 8'hAA, 8'h00); chk(periph_ptr, 8'h18);
        rreg(OFS_READ_DATA); chk(reg_rdata, e);
        {lat, read_access_size} <= {4'h7, 1'b1};
        op(0, 0, 8'h00, PA_DATA_LO);
        op(0, 1, 8'h00, 8'h00);
        wait_idle;
        chk(access_success_flag, 0);
        op(0, 0, 8'h00, PA_STATUS);
        op(0, 1, 8'h00, 8'h00);
        chk(byte_rdata, 8'h00);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        chk(periph_ptr, 8'h00);
        rreg(OFS_READ_ADDRESS);
        chk(reg_rdata, RST_WORD);
        rreg(OFS_READ_DATA);
        chk(reg_rdata, RST_WORD);
        rreg(20'h00000); chk(reg_rdata, 0);
        $display("test corners done");
        summarize;
    end
endmodule : testbench
bind ind_read_path ind_read_chk chk_u (.clk_sys, .reset, .byte_wr, .byte_rd, .ptr_load,
    .read_access_size, .read_busy, .ibus_rd, .ibus_done, .ibus_ok, .access_success_flag,
    .periph_ptr, .ibus_addr);
